// ---- design/timer_cfg.svh ----
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
// register byte offsets
`define A_SEL    5'h00
`define A_FORCE  5'h01
`define A_MASK3  5'h02
`define A_DATA3  5'h03
`define A_CNTH   5'h04
`define A_CNTL   5'h05
`define A_SC1    5'h06
`define A_TOV    5'h08
`define A_ACT    5'h09
`define A_EDGE   5'h0B
`define A_IE     5'h0C
`define A_SC2    5'h0D
`define A_FLG1   5'h0E
`define A_FLG2   5'h0F
`define CH_SEL   2'h2
`define A_PACTL  5'h18
`define A_PAFLG  5'h19
`define A_PACH   5'h1A
`define A_PACL   5'h1B
`define A_PORT   5'h1D
`define A_DDR    5'h1E
`define A_TEST   5'h1F
// field positions
`define SC1_RUN  7
`define SC2_TOIE 7
`define SC2_PULL 5
`define SC2_PRE  2:0
`define FLG2_TOF 7
`define PA_EN    6
`define PA_GATED 5
`define PA_FALL  4
`define PA_IE    1:0
`define TEST_BYP 0
// values
`define ZERO4    4'h0
`define ZERO8    8'h00
`define ZERO16   16'h0000
`define ONE8     8'h01
`define ONE16    16'h0001
`define CNT_MAX  16'hFFFF
`define PRE_ONES 8'hFF
`define ALL_CH   3'h7
`endif

// ---- design/timer_pkg.sv ----
package timer_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] nib_t;
    typedef logic [4:0] addr_t;
    typedef enum logic [1:0] {
        ACT_NONE   = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_CLEAR  = 2'h2,
        ACT_SET    = 2'h3
    } pin_action_t;
endpackage : timer_pkg

// ---- design/capture_compare_timer.sv ----
// Notes on behaviour
// - 16-bit up-counter clocked through a seven-stage power-of-two prescaler.
// - four channels, each separately input capture or output compare.
// - only channel 3 may instead feed the pulse accumulator.
// - counter wrap from all ones sets an overflow flag.
// - capture latches the counter on the selected pin edge.
// - compare acts on the pin when counter equals channel value.
// - 16-bit accumulator counts edges or gated prescaler ticks.
// - event mode takes its input from the channel 3 pin.
// - per-channel toggle of the pin on each counter overflow.
// - pull-up option sampled at reset enables the port pull-ups.
// - non-supervisor accesses are refused with a transfer error.
// - clearing run enable or accumulator enable stops all functions.
// - stop mode halts operation; it resumes from the held state.
// - wait, doze and debug modes do not affect the timer.
// - test register reachable only in test mode.
// - pins without timer function are port data and direction I/O.
// - channel 3 pin serves channel 3 or the accumulator.
// - select bit one means compare, zero means capture.
// - forced compare does the pin action but sets no flag.
// - channel 3 compare wins; masked pins take channel 3 data.
// - counter writes work only in test mode; reads always.
`timescale 1ns/100ps
`default_nettype none
`include "timer_cfg.svh"

module capture_compare_timer (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             clock_en,
    input  wire timer_pkg::addr_t addr,
    input  wire timer_pkg::byte_t wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output var  timer_pkg::byte_t rdata,
    output logic                  bus_error,
    input  wire logic             supervisor,
    input  wire logic             test_mode,
    input  wire logic             stop_mode,
    input  wire logic             pullup_option,
    input  wire timer_pkg::nib_t  pin_in,
    output var  timer_pkg::nib_t  pin_out,
    output var  timer_pkg::nib_t  pin_oe_n,
    output var  timer_pkg::nib_t  pin_pullup,
    output logic                  irq
);
    import timer_pkg::*;

    nib_t        sel_r, sel_nxt, mask3_r, mask3_nxt, data3_r, data3_nxt;
    nib_t        tov_r, tov_nxt, ie_r, ie_nxt, flg1_r, flg1_nxt;
    nib_t        port_r, port_nxt, ddr_r, ddr_nxt, prev_r;
    byte_t       sc1_r, sc1_nxt, act_r, act_nxt, edge_r, edge_nxt;
    byte_t       sc2_r, sc2_nxt, pactl_r, pactl_nxt, test_r, test_nxt;
    byte_t       pre_r, pre_nxt, rdata_nxt, rd_mux, pre_mask;
    logic [15:0] cnt_r, cnt_nxt, pacnt_r, pacnt_nxt;
    logic [15:0] chan_r [4];
    logic [15:0] chan_nxt [4];
    logic [1:0]  paflg_r, paflg_nxt, paf_clr;
    logic        tof_r, tof_nxt, tof_clr, pull_r, pull_nxt, err_nxt;
    nib_t        flg_clr, rise, fall, live, cap, match, frc;
    nib_t        drv, out_en, hw_en, hw_val, port_rd;
    logic        wr_ok, rd_ok, run, tick, ovf, hit3, pa_event;
    logic        pa_edge, pa_inc, pa_ovf;

    // bus qualification: user mode never reaches the register file
    assign wr_ok = wr & supervisor;
    assign rd_ok = rd & supervisor;

    // wait, doze and debug have no input here, so they cannot stop it
    assign run = sc1_r[`SC1_RUN] & pactl_r[`PA_EN] & ~stop_mode;

    // low sel bits of the free-running prescaler all ones gives 2**sel
    assign pre_mask = ~(`PRE_ONES << sc2_r[`SC2_PRE]);
    assign tick = run & (((pre_r & pre_mask) == pre_mask) |
                         (test_mode & test_r[`TEST_BYP]));
    assign ovf  = tick & (cnt_r == `CNT_MAX);

    // event mode claims the channel 3 pin from capture and compare
    assign pa_event = pactl_r[`PA_EN] & ~pactl_r[`PA_GATED];
    assign live = {~pa_event, `ALL_CH};
    assign rise = pin_in & ~prev_r;
    assign fall = ~pin_in & prev_r;
    assign hit3 = match[3] | frc[3];

    // per-channel capture, compare and pin ownership
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic [1:0]  edg;
        pin_action_t act;
        assign edg = edge_r[2*i +: 2];
        assign act = pin_action_t'(act_r[2*i +: 2]);
        assign cap[i] = run & live[i] & ~sel_r[i] &
                        ((edg[0] & rise[i]) | (edg[1] & fall[i]));
        assign match[i] = tick & live[i] & sel_r[i] &
                          (cnt_r == chan_r[i]);
        // a disabled timer ignores forces as it ignores matches
        assign frc[i] = run & wr_ok & (addr == `A_FORCE) &
                        wdata[i] & sel_r[i];
        // channel 3 mask overrides this channel's own action
        assign hw_en[i] = (hit3 & mask3_r[i]) |
                          ((match[i] | frc[i]) & (act != ACT_NONE)) |
                          (ovf & tov_r[i]);
        assign hw_val[i] = (hit3 & mask3_r[i]) ? data3_r[i] :
                           ((match[i] | frc[i]) & (act != ACT_NONE)) ?
                           ((act == ACT_TOGGLE) ? ~port_r[i] :
                            (act == ACT_SET)) : ~port_r[i];
        assign drv[i] = sel_r[i] & live[i] &
                        ((act != ACT_NONE) | tov_r[i] | mask3_r[i]);
    end

    // pins: timer drive, else direction register
    assign out_en     = drv | ddr_r;
    assign pin_oe_n   = ~out_en;
    assign pin_out    = port_r;
    assign port_rd    = (port_r & out_en) | (pin_in & ~out_en);
    assign pin_pullup = {4{pull_r}};

    // accumulator: edges in event mode, ticks while pin active if gated
    assign pa_edge = pactl_r[`PA_FALL] ? fall[3] : rise[3];
    assign pa_inc  = run & (pactl_r[`PA_GATED] ?
                     (tick & (pin_in[3] ^ pactl_r[`PA_FALL])) :
                     pa_edge);
    assign pa_ovf  = pa_inc & (pacnt_r == `CNT_MAX);

    assign irq = (|(flg1_r & ie_r)) | (tof_r & sc2_r[`SC2_TOIE]) |
                 (|(paflg_r & pactl_r[`PA_IE]));

    // read decode; refused, reserved and write-only reads give zero
    always_comb begin
        rd_mux = `ZERO8;
        if (addr == `A_SEL) begin
            rd_mux = {`ZERO4, sel_r};
        end else if (addr == `A_MASK3) begin
            rd_mux = {`ZERO4, mask3_r};
        end else if (addr == `A_DATA3) begin
            rd_mux = {`ZERO4, data3_r};
        end else if (addr == `A_CNTH) begin
            rd_mux = cnt_r[15:8];
        end else if (addr == `A_CNTL) begin
            rd_mux = cnt_r[7:0];
        end else if (addr == `A_SC1) begin
            rd_mux = sc1_r;
        end else if (addr == `A_TOV) begin
            rd_mux = {`ZERO4, tov_r};
        end else if (addr == `A_ACT) begin
            rd_mux = act_r;
        end else if (addr == `A_EDGE) begin
            rd_mux = edge_r;
        end else if (addr == `A_IE) begin
            rd_mux = {`ZERO4, ie_r};
        end else if (addr == `A_SC2) begin
            rd_mux = sc2_r;
            rd_mux[`SC2_PULL] = pull_r;
        end else if (addr == `A_FLG1) begin
            rd_mux = {`ZERO4, flg1_r};
        end else if (addr == `A_FLG2) begin
            rd_mux[`FLG2_TOF] = tof_r;
        end else if (addr[4:3] == `CH_SEL) begin
            rd_mux = addr[0] ? chan_r[addr[2:1]][7:0]
                             : chan_r[addr[2:1]][15:8];
        end else if (addr == `A_PACTL) begin
            rd_mux = pactl_r;
        end else if (addr == `A_PAFLG) begin
            rd_mux[1:0] = paflg_r;
        end else if (addr == `A_PACH) begin
            rd_mux = pacnt_r[15:8];
        end else if (addr == `A_PACL) begin
            rd_mux = pacnt_r[7:0];
        end else if (addr == `A_PORT) begin
            rd_mux = {`ZERO4, port_rd};
        end else if (addr == `A_DDR) begin
            rd_mux = {`ZERO4, ddr_r};
        end else if (addr == `A_TEST && test_mode) begin
            rd_mux = test_r;
        end
    end

    // next state: counter and prescaler steps, then software writes, hardware events override
    always_comb begin
        sel_nxt = sel_r;     mask3_nxt = mask3_r; data3_nxt = data3_r;
        sc1_nxt = sc1_r;     tov_nxt = tov_r;     act_nxt = act_r;
        edge_nxt = edge_r;   ie_nxt = ie_r;       sc2_nxt = sc2_r;
        pactl_nxt = pactl_r; ddr_nxt = ddr_r;     test_nxt = test_r;
        pull_nxt = pull_r;   port_nxt = port_r;   pacnt_nxt = pacnt_r;
        chan_nxt = chan_r;
        flg_clr = `ZERO4;
        tof_clr = 1'b0;
        paf_clr = 2'h0;
        cnt_nxt = tick ? cnt_r + `ONE16 : cnt_r;
        pre_nxt = run ? pre_r + `ONE8 : pre_r;
        if (wr_ok) begin
            if (addr == `A_SEL) begin
                sel_nxt = wdata[3:0];
            end else if (addr == `A_MASK3) begin
                mask3_nxt = wdata[3:0];
            end else if (addr == `A_DATA3) begin
                data3_nxt = wdata[3:0];
            end else if (addr == `A_CNTH && test_mode) begin
                cnt_nxt[15:8] = wdata;
            end else if (addr == `A_CNTL && test_mode) begin
                cnt_nxt[7:0] = wdata;
            end else if (addr == `A_SC1) begin
                sc1_nxt = wdata;
            end else if (addr == `A_TOV) begin
                tov_nxt = wdata[3:0];
            end else if (addr == `A_ACT) begin
                act_nxt = wdata;
            end else if (addr == `A_EDGE) begin
                edge_nxt = wdata;
            end else if (addr == `A_IE) begin
                ie_nxt = wdata[3:0];
            end else if (addr == `A_SC2) begin
                sc2_nxt = wdata;
                pull_nxt = wdata[`SC2_PULL];
                pre_nxt = `ZERO8; // new division starts clean
            end else if (addr == `A_FLG1) begin
                flg_clr = wdata[3:0];
            end else if (addr == `A_FLG2) begin
                tof_clr = wdata[`FLG2_TOF];
            end else if (addr[4:3] == `CH_SEL) begin
                if (addr[0]) begin
                    chan_nxt[addr[2:1]][7:0] = wdata;
                end else begin
                    chan_nxt[addr[2:1]][15:8] = wdata;
                end
            end else if (addr == `A_PACTL) begin
                pactl_nxt = wdata;
            end else if (addr == `A_PAFLG) begin
                paf_clr = wdata[1:0];
            end else if (addr == `A_PACH) begin
                pacnt_nxt[15:8] = wdata;
            end else if (addr == `A_PACL) begin
                pacnt_nxt[7:0] = wdata;
            end else if (addr == `A_PORT) begin
                port_nxt = wdata[3:0];
            end else if (addr == `A_DDR) begin
                ddr_nxt = wdata[3:0];
            end else if (addr == `A_TEST && test_mode) begin
                test_nxt = wdata;
            end
        end
        for (int k = 0; k < 4; k++) begin
            if (cap[k]) begin
                chan_nxt[k] = cnt_r;
            end
        end
        port_nxt = (port_nxt & ~hw_en) | (hw_val & hw_en);
        if (pa_inc) begin
            pacnt_nxt = pacnt_r + `ONE16;
        end
        // a set in the same cycle as its clear is kept
        flg1_nxt = (flg1_r & ~flg_clr) | cap | match;
        tof_nxt = (tof_r & ~tof_clr) | ovf;
        paflg_nxt = (paflg_r & ~paf_clr) |
                    {pa_ovf, run & pa_edge & pa_event};
        rdata_nxt = rd_ok ? rd_mux : `ZERO8;
        err_nxt = (wr | rd) & ~supervisor;
    end

    // state registers; clock_en low freezes everything
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sel_r <= `ZERO4;   mask3_r <= `ZERO4; data3_r <= `ZERO4;
            tov_r <= `ZERO4;   ie_r <= `ZERO4;    flg1_r <= `ZERO4;
            port_r <= `ZERO4;  ddr_r <= `ZERO4;   prev_r <= `ZERO4;
            sc1_r <= `ZERO8;   act_r <= `ZERO8;   edge_r <= `ZERO8;
            sc2_r <= `ZERO8;   pactl_r <= `ZERO8; test_r <= `ZERO8;
            pre_r <= `ZERO8;   rdata <= `ZERO8;   cnt_r <= `ZERO16;
            pacnt_r <= `ZERO16;
            chan_r <= '{default: `ZERO16};
            paflg_r <= 2'h0;
            tof_r <= 1'b0;
            bus_error <= 1'b0;
            pull_r <= pullup_option;
        end else if (clock_en) begin
            sel_r <= sel_nxt;   mask3_r <= mask3_nxt; data3_r <= data3_nxt;
            tov_r <= tov_nxt;   ie_r <= ie_nxt;       flg1_r <= flg1_nxt;
            port_r <= port_nxt; ddr_r <= ddr_nxt;     prev_r <= pin_in;
            sc1_r <= sc1_nxt;   act_r <= act_nxt;     edge_r <= edge_nxt;
            sc2_r <= sc2_nxt;   pactl_r <= pactl_nxt; test_r <= test_nxt;
            pre_r <= pre_nxt;   rdata <= rdata_nxt;   cnt_r <= cnt_nxt;
            pacnt_r <= pacnt_nxt;
            chan_r <= chan_nxt;
            paflg_r <= paflg_nxt;
            tof_r <= tof_nxt;
            bus_error <= err_nxt;
            pull_r <= pull_nxt;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence stop_held_s;
        (stop_mode && !wr) [*3];
    endsequence

    user_denied_a: assert property (rd && !supervisor && clock_en |=>
        bus_error && rdata == `ZERO8)
        else $error("user read not refused");
    cnt_locked_a: assert property (wr && !test_mode &&
        (addr == `A_CNTH || addr == `A_CNTL) && !tick && clock_en |=>
        cnt_r == $past(cnt_r))
        else $error("counter written outside test mode");
    overflow_flag_a: assert property (ovf && clock_en |=> tof_r &&
        cnt_r == `ZERO16)
        else $error("overflow not flagged");
    capture_value_a: assert property (cap[0] && clock_en |=>
        chan_r[0] == $past(cnt_r) && flg1_r[0])
        else $error("capture missed counter value");
    force_noflag_a: assert property (frc[2] && !match[2] && clock_en
        |=> flg1_r[2] == $past(flg1_r[2]))
        else $error("forced compare changed flag");
    ch3_priority_a: assert property (hit3 && mask3_r[2] && clock_en
        |=> port_r[2] == $past(data3_r[2]))
        else $error("channel 3 data not applied");
    stop_halt_a: assert property (stop_held_s |->
        cnt_r == $past(cnt_r, 2))
        else $error("counter moved in stop mode");
    gpio_dir_a: assert property (!sel_r[1] |-> pin_oe_n[1] == !ddr_r[1])
        else $error("gpio direction not honoured");
    tov_toggle_a: assert property (ovf && tov_r[0] &&
        !(hit3 && mask3_r[0]) && !(match[0] || frc[0]) && clock_en &&
        !(wr && addr == `A_PORT) |=> port_r[0] != $past(port_r[0]))
        else $error("pin did not toggle on overflow");
endmodule : capture_compare_timer
`default_nettype wire

// ---- verif/pin_partner.sv ----
`timescale 1ns/100ps
`default_nettype none

// far side of the timer port: external drivers, pull-ups and a floating wire
module pin_partner (
    input  wire logic            clock,
    input  wire timer_pkg::nib_t pin_out,
    input  wire timer_pkg::nib_t pin_oe_n,
    input  wire timer_pkg::nib_t pin_pullup,
    input  wire timer_pkg::nib_t ext_en,
    input  wire timer_pkg::nib_t ext_val,
    output var  timer_pkg::nib_t pin_level
);
    import timer_pkg::*;

    nib_t last_r = 4'h0;

    // the timer wins over the outside driver; an undriven pin without
    // pull-up flips each cycle so a stale value never looks valid
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!pin_oe_n[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = ~last_r[i];
        end
    end

    // remember the last level for the floating case
    always_ff @(posedge clock) begin
        last_r <= pin_level;
    end
endmodule : pin_partner

`default_nettype wire

// ---- verif/four_channel_capture_compare_timer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "timer_cfg.svh"

module four_channel_capture_compare_timer_tb;
    import timer_pkg::*;

    logic  clock = 1'b0;
    logic  resetn = 1'b0;
    addr_t addr = 5'h00;
    byte_t wdata = 8'h00;
    logic  wr = 1'b0;
    logic  rd = 1'b0;
    logic  supervisor = 1'b1;
    logic  test_mode = 1'b0;
    logic  stop_mode = 1'b0;
    logic  clock_en = 1'b1;
    logic  pullup_option = 1'b1;
    nib_t  ext_en = 4'h0;
    nib_t  ext_val = 4'h0;
    byte_t rdata;
    logic  bus_error;
    logic  irq;
    nib_t  pin_level, pin_out, pin_oe_n, pin_pullup;
    logic  err_seen, p;
    byte_t d, d2, e;
    int    mismatches = 0;
    int    check_count = 0;

    // 25 MHz system clock
    initial begin
        forever #20 clock = ~clock;
    end

    capture_compare_timer u_capture_compare_timer (
        .clock(clock), .resetn(resetn), .clock_en(clock_en), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .bus_error(bus_error), .supervisor(supervisor),
        .test_mode(test_mode), .stop_mode(stop_mode),
        .pullup_option(pullup_option), .pin_in(pin_level),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .irq(irq));

    pin_partner u_pin_partner (
        .clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
        .pin_level(pin_level));

    task automatic fail(input string msg);
        mismatches++;
        $display("[ERR] %0t %s", $time, msg);
    endtask : fail

    task automatic check8(input byte_t got, input byte_t exp);
        check_count++;
        if (got !== exp) fail($sformatf("byte %h, want %h", got, exp));
    endtask : check8

    task automatic check4(input nib_t got, input nib_t exp);
        check_count++;
        if (got !== exp) fail($sformatf("pins %h, want %h", got, exp));
    endtask : check4

    task automatic check1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) fail($sformatf("bit %b, want %b", got, exp));
    endtask : check1

    // one strobe cycle; answer and error are taken in the cycle after
    task automatic bus(input logic w, input addr_t a, input byte_t v);
        @(posedge clock);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= v;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        d = rdata;
        err_seen = bus_error;
    endtask : bus

    task automatic wreg(input addr_t a, input byte_t v);
        bus(1'b1, a, v);
    endtask : wreg

    task automatic rreg(input addr_t a);
        bus(1'b0, a, 8'h00);
    endtask : rreg

    task automatic rchk(input addr_t a, input byte_t exp);
        rreg(a);
        check8(d, exp);
    endtask : rchk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    // poll a register until a masked bit shows; bounded so a hang ends
    task automatic wait_rd(input addr_t a, input byte_t m);
        int k;
        for (k = 0; k < 100; k++) begin
            rreg(a);
            if ((d & m) !== 8'h00) break;
        end
        if (k == 100) begin
            fail("flag wait timed out");
            test_done();
        end
    endtask : wait_rd

    task automatic pulse3(input int n);
        cyc(1);
        repeat (n) begin
            ext_val[3] <= 1'b1;
            cyc(2);
            ext_val[3] <= 1'b0;
            cyc(2);
        end
    endtask : pulse3

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        cyc(12);
        resetn <= 1'b1;
        check4(pin_pullup, 4'hF);
        check4(pin_oe_n, 4'hF);
        check1(irq, 1'b0);
        rchk(`A_PORT, 8'h0F);
        cyc(1);
        ext_en <= 4'hF;
        end_test("reset");
        // user-mode accesses are refused
        cyc(1);
        supervisor <= 1'b0;
        wreg(`A_SEL, 8'h0F);
        check1(err_seen, 1'b1);
        rchk(`A_SEL, 8'h00);
        check1(err_seen, 1'b1);
        cyc(1);
        supervisor <= 1'b1;
        rchk(`A_SEL, 8'h00);
        check1(err_seen, 1'b0);
        rchk(5'h07, 8'h00);
        check1(err_seen, 1'b0);
        end_test("supervisor");
        // counter and test register writable only in test mode
        wreg(`A_CNTH, 8'h12);
        rchk(`A_CNTH, 8'h00);
        wreg(`A_TEST, 8'h01);
        rchk(`A_TEST, 8'h00);
        cyc(1);
        test_mode <= 1'b1;
        wreg(`A_TEST, 8'h01);
        rchk(`A_TEST, 8'h01);
        wreg(`A_TEST, 8'h00);
        wreg(`A_CNTH, 8'h12);
        wreg(`A_CNTL, 8'h34);
        rchk(`A_CNTH, 8'h12);
        rchk(`A_CNTL, 8'h34);
        end_test("test mode");
        // slow prescale keeps the counter near 0x1234 during capture
        wreg(`A_SC2, 8'h07);
        wreg(`A_EDGE, 8'h01);
        wreg(`A_IE, 8'h01);
        wreg(`A_SC1, 8'h80);
        wreg(`A_PACTL, 8'h40);
        cyc(1);
        ext_val <= 4'h1;
        cyc(3);
        check1(irq, 1'b1);
        rchk(`A_FLG1, 8'h01);
        rchk(5'h10, 8'h12);
        rreg(5'h11);
        check1(d == 8'h34 || d == 8'h35, 1'b1);
        wreg(`A_FLG1, 8'h01);
        rchk(`A_FLG1, 8'h00);
        check1(irq, 1'b0);
        end_test("capture");
        // stop mode freezes the counter, release resumes it
        wreg(`A_SC2, 8'h00);
        cyc(1);
        stop_mode <= 1'b1;
        rreg(`A_CNTL);
        d2 = d;
        cyc(5);
        rchk(`A_CNTL, d2);
        cyc(1);
        stop_mode <= 1'b0;
        rreg(`A_CNTL);
        check1(d !== d2, 1'b1);
        // clock enable low: only three enabled edges between the reads
        d2 = d;
        cyc(1);
        clock_en <= 1'b0;
        cyc(5);
        clock_en <= 1'b1;
        rreg(`A_CNTL);
        check8(d, d2 + 8'h03);
        end_test("stop");
        // channel 1 compare sets its pin on match
        wreg(`A_SEL, 8'h02);
        wreg(`A_ACT, 8'h0C);
        wreg(`A_DDR, 8'h02);
        wreg(5'h12, 8'h20);
        wreg(5'h13, 8'h00);
        wreg(`A_CNTL, 8'hF0);
        wreg(`A_CNTH, 8'h1F);
        wait_rd(`A_FLG1, 8'h02);
        check8(d, 8'h02);
        check1(pin_out[1], 1'b1);
        check1(pin_oe_n[1], 1'b0);
        end_test("compare");
        // forced compare toggles the pin without a flag
        wreg(`A_FLG1, 8'hFF);
        wreg(`A_SEL, 8'h06);
        wreg(`A_ACT, 8'h1C);
        wreg(`A_DDR, 8'h06);
        p = pin_out[2];
        wreg(`A_FORCE, 8'h04);
        cyc(1);
        check1(pin_out[2], ~p);
        rchk(`A_FLG1, 8'h00);
        // channel 3 force beats channel 2's toggle on masked pin 2
        wreg(`A_MASK3, 8'h04);
        p = pin_out[2];
        wreg(`A_DATA3, {5'h00, p, 2'h0});
        wreg(`A_SEL, 8'h0E);
        wreg(`A_FORCE, 8'h0C);
        cyc(1);
        check1(pin_out[2], p);
        end_test("force");
        // wrap from all ones: overflow flag and toggle on overflow
        wreg(`A_SEL, 8'h07);
        wreg(`A_TOV, 8'h01);
        wreg(`A_DDR, 8'h07);
        p = pin_out[0];
        wreg(`A_CNTL, 8'hF0);
        wreg(`A_CNTH, 8'hFF);
        wait_rd(`A_FLG2, 8'h80);
        check1(pin_out[0], ~p);
        check1(irq, 1'b0);
        wreg(`A_SC2, 8'h80);
        check1(irq, 1'b1);
        wreg(`A_SC2, 8'h00);
        wreg(`A_FLG2, 8'h80);
        end_test("overflow");
        // event counting on the channel 3 pin
        rreg(`A_PACL);
        e = d + 8'h05;
        pulse3(5);
        rchk(`A_PACL, e);
        // accumulator enable cleared: everything stops
        wreg(`A_PACTL, 8'h00);
        rreg(`A_CNTL);
        d2 = d;
        pulse3(2);
        rchk(`A_CNTL, d2);
        rchk(`A_PACL, e);
        end_test("accumulator");
        // general-purpose pins with timer idle
        wreg(`A_ACT, 8'h00);
        wreg(`A_TOV, 8'h00);
        wreg(`A_SEL, 8'h00);
        wreg(`A_DDR, 8'h00);
        cyc(1);
        ext_val <= 4'hA;
        rchk(`A_PORT, 8'h0A);
        wreg(`A_DDR, 8'h0F);
        wreg(`A_PORT, 8'h05);
        check4(pin_out, 4'h5);
        check4(pin_oe_n, 4'h0);
        check4(pin_level, 4'h5);
        end_test("port");
        // second reset with the pull-up option off
        cyc(1);
        resetn <= 1'b0;
        pullup_option <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        check4(pin_pullup, 4'h0);
        check4(pin_oe_n, 4'hF);
        rchk(`A_SC2, 8'h00);
        end_test("reset again");
        test_done();
    end
endmodule : four_channel_capture_compare_timer_tb

`default_nettype wire
